// >>> rtl/smart_status_defines.svh
`ifndef SMART_STATUS_DEFINES_SVH
`define SMART_STATUS_DEFINES_SVH

// subcommand codes
`define SUB_RETURN_STATUS 8'hda
`define SUB_AUTO_OFFLINE 8'hdb
`define SUB_READ_VALUES 8'hd0

// reliability answers on the cylinder registers
`define CYL_LO_GOOD 8'h4f
`define CYL_HI_GOOD 8'hc2
`define CYL_LO_BAD 8'hf4
`define CYL_HI_BAD 8'h2c

// automatic off-line keys in sector count
`define AUTO_OFF_KEY 8'h00
`define AUTO_ON_KEY 8'hf8

// supported attribute identifiers
`define ID_READ_ERR 8'h01
`define ID_THROUGHPUT 8'h02
`define ID_SPIN_UP 8'h03
`define ID_START_STOP 8'h04
`define ID_REALLOC 8'h05
`define ID_SEEK_ERR 8'h07
`define ID_SEEK_TIME 8'h08
`define ID_POWER_ON 8'h09
`define ID_SPIN_RETRY 8'h0a
`define ID_POWER_CYCLE 8'h0c
`define ID_RETRACT 8'hc0
`define ID_LOAD_CYCLE 8'hc1
`define ID_TEMPERATURE 8'hc2
`define ID_REALLOC_EVENT 8'hc4
`define ID_PENDING 8'hc5
`define ID_OFFLINE_UNC 8'hc6
`define ID_CRC_ERR 8'hc7

// structure layout
`define STRUCT_LAST 9'h1ff
`define REV_LO_OFS 9'h000
`define REV_HI_OFS 9'h001
`define ENTRY_BASE 9'h002
`define ENTRY_END 9'h16a
`define ENTRY_BYTES 4'hc
`define ENTRY_LAST_IDX 4'hb
`define ENTRY_COUNT 5'h1e
`define ENT_ID 4'h0
`define ENT_FLAG_LO 4'h1
`define ENT_FLAG_HI 4'h2
`define ENT_VALUE 4'h3
`define OFL_STATUS_OFS 9'h16a
`define SELFTEST_OFS 9'h16b
`define OFL_TIME_LO_OFS 9'h16c
`define OFL_TIME_HI_OFS 9'h16d
`define SEGMENT_OFS 9'h16e
`define OFL_CAP_OFS 9'h16f
`define MON_CAP_LO_OFS 9'h170
`define MON_CAP_HI_OFS 9'h171
`define ERRLOG_CAP_OFS 9'h172

// fixed contents
`define REV_NUMBER 16'h0010
`define OFL_CAP_VAL 8'h1b
`define MON_CAP_VAL 16'h0003
`define ERRLOG_CAP_VAL 8'h01
`define VALUE_MIN 8'h01
`define VALUE_MAX 8'hfd
`define FLAG_KEEP_MASK 8'h3f

`endif

// >>> rtl/smart_status_pkg.sv
package smart_status_pkg;

   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_EVAL = 2'b01,
      ST_SEND = 2'b10,
      ST_DONE = 2'b11
   } phase_t;

   typedef struct packed
   {
      phase_t phase;
      logic [7:0] sub;
      logic [8:0] ofs;
      logic [4:0] idx;
      logic [3:0] sub_ofs;
      logic [7:0] sum;
      logic auto_en;
      logic busy;
      logic intrq;
      logic [7:0] cyl_lo;
      logic [7:0] cyl_hi;
      logic [7:0] rd_data;
      logic rd_valid;
      logic err;
      logic save_req;
   } state_t;

endpackage : smart_status_pkg

// >>> rtl/smart_status_attribute_report.sv
`timescale 1ns/1ps
`include "smart_status_defines.svh"

module smart_status_attribute_report
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_sub,
   input wire logic [7:0] cmd_sector_count,
   input wire logic [29:0][7:0] attr_id,
   input wire logic [29:0][7:0] attr_flags,
   input wire logic [29:0][7:0] attr_value,
   input wire logic [29:0][7:0] attr_threshold,
   input wire logic [29:0] attr_updated,
   input wire logic [6:0] offline_state,
   input wire logic [7:0] selftest_status,
   input wire logic [15:0] offline_seconds,
   input wire logic [7:0] segment_ptr,
   input wire logic intrq_ack,
   output logic busy,
   output logic intrq,
   output logic [7:0] cyl_low,
   output logic [7:0] cyl_high,
   output logic [7:0] data_byte,
   output logic data_valid,
   output logic cmd_error,
   output logic auto_offline_en,
   output logic save_req
);

   smart_status_pkg::state_t s_q;
   smart_status_pkg::state_t s_d;

   logic [29:0] entry_ok;
   logic [29:0] exceeded;
   logic [29:0][7:0] clamped;

   logic [7:0] entry_byte;
   logic [7:0] out_byte;
   logic in_entries;
   logic [15:0] rev_word;
   logic [15:0] mon_word;
   logic key_off;
   logic key_on;

   // -------------------------------------------------------------------
   // per-entry qualification
   // -------------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < `ENTRY_COUNT; g = g + 1)
      begin : g_entry
         logic ok;
         logic [7:0] nv;

         // unsupported ids are blanked to an all-zero entry
         always_comb
         begin
            case (attr_id[g])
               `ID_READ_ERR,
               `ID_THROUGHPUT,
               `ID_SPIN_UP,
               `ID_START_STOP,
               `ID_REALLOC,
               `ID_SEEK_ERR,
               `ID_SEEK_TIME,
               `ID_POWER_ON,
               `ID_SPIN_RETRY,
               `ID_POWER_CYCLE,
               `ID_RETRACT,
               `ID_LOAD_CYCLE,
               `ID_TEMPERATURE,
               `ID_REALLOC_EVENT,
               `ID_PENDING,
               `ID_OFFLINE_UNC,
               `ID_CRC_ERR: ok = 1'b1;
               default: ok = 1'b0;
            endcase
         end

         // out-of-range values never reach the host
         always_comb
         begin
            nv = attr_value[g];
            if (nv < `VALUE_MIN)
               nv = `VALUE_MIN;
            else if (nv > `VALUE_MAX)
               nv = `VALUE_MAX;
         end

         assign entry_ok[g] = ok;
         assign clamped[g] = nv;
         // only updated pre-failure entries count; values are normalized
         assign exceeded[g] = ok && attr_updated[g] && attr_flags[g][0] &&
            attr_value[g] <= attr_threshold[g];
      end
   endgenerate

   // -------------------------------------------------------------------
   // byte of the current entry
   // -------------------------------------------------------------------
   always_comb
   begin
      logic [4:0] pick;
      pick = s_q.idx;
      // the cursor steps past the last entry on leaving the entry area
      if (pick >= `ENTRY_COUNT)
         pick = 5'h00;
      entry_byte = 8'h00;
      if (entry_ok[pick])
      begin
         case (s_q.sub_ofs)
            `ENT_ID: entry_byte = attr_id[pick];
            `ENT_FLAG_LO:
               entry_byte = attr_flags[pick] & `FLAG_KEEP_MASK;
            `ENT_FLAG_HI: entry_byte = 8'h00;
            `ENT_VALUE: entry_byte = clamped[pick];
            default: entry_byte = 8'h00;
         endcase
      end
   end

   // -------------------------------------------------------------------
   // structure byte at the current offset
   // -------------------------------------------------------------------
   // literals cannot be part-selected, so the fixed words are staged
   assign rev_word = `REV_NUMBER;
   assign mon_word = `MON_CAP_VAL;
   assign in_entries = s_q.ofs >= `ENTRY_BASE && s_q.ofs < `ENTRY_END;

   always_comb
   begin
      out_byte = 8'h00;
      if (in_entries)
         out_byte = entry_byte;
      else
      begin
         case (s_q.ofs)
            `REV_LO_OFS: out_byte = rev_word[7:0];
            `REV_HI_OFS: out_byte = rev_word[15:8];
            `OFL_STATUS_OFS:
               out_byte = {s_q.auto_en, offline_state};
            `SELFTEST_OFS: out_byte = selftest_status;
            `OFL_TIME_LO_OFS: out_byte = offline_seconds[7:0];
            `OFL_TIME_HI_OFS: out_byte = offline_seconds[15:8];
            `SEGMENT_OFS: out_byte = segment_ptr;
            `OFL_CAP_OFS: out_byte = `OFL_CAP_VAL;
            `MON_CAP_LO_OFS: out_byte = mon_word[7:0];
            `MON_CAP_HI_OFS: out_byte = mon_word[15:8];
            `ERRLOG_CAP_OFS: out_byte = `ERRLOG_CAP_VAL;
            // the sum stops one byte short, so the block adds to zero
            `STRUCT_LAST: out_byte = 8'h00 - s_q.sum;
            default: out_byte = 8'h00;
         endcase
      end
   end

   // -------------------------------------------------------------------
   // sector count keys, read while the command is evaluated
   // -------------------------------------------------------------------
   assign key_off = cmd_sector_count == `AUTO_OFF_KEY;
   assign key_on = cmd_sector_count == `AUTO_ON_KEY;

   // -------------------------------------------------------------------
   // command sequencing
   // -------------------------------------------------------------------
   always_comb
   begin
      s_d = s_q;
      s_d.rd_valid = 1'b0;
      s_d.save_req = 1'b0;
      if (intrq_ack)
         s_d.intrq = 1'b0;
      case (s_q.phase)
         smart_status_pkg::ST_IDLE:
         begin
            // commands that arrive while busy are dropped without notice
            if (cmd_valid)
            begin
               s_d.sub = cmd_sub;
               s_d.busy = 1'b1;
               s_d.intrq = 1'b0;
               s_d.err = 1'b0;
               s_d.ofs = 9'h000;
               s_d.idx = 5'h00;
               s_d.sub_ofs = 4'h0;
               s_d.sum = 8'h00;
               s_d.phase = smart_status_pkg::ST_EVAL;
            end
         end
         smart_status_pkg::ST_EVAL:
         begin
            s_d.phase = smart_status_pkg::ST_DONE;
            case (s_q.sub)
               `SUB_RETURN_STATUS:
               begin
                  // save is pulsed in the same cycle that the compare result is loaded
                  s_d.save_req = 1'b1;
                  // the answer holds until the next status command
                  if (|exceeded)
                  begin
                     s_d.cyl_lo = `CYL_LO_BAD;
                     s_d.cyl_hi = `CYL_HI_BAD;
                  end
                  else
                  begin
                     s_d.cyl_lo = `CYL_LO_GOOD;
                     s_d.cyl_hi = `CYL_HI_GOOD;
                  end
               end
               `SUB_AUTO_OFFLINE:
               begin
                  if (key_off)
                     s_d.auto_en = 1'b0;
                  else if (key_on)
                     s_d.auto_en = 1'b1;
                  // other keys leave the feature alone and only flag
                  else
                     s_d.err = 1'b1;
               end
               `SUB_READ_VALUES: s_d.phase = smart_status_pkg::ST_SEND;
               default: s_d.err = 1'b1;
            endcase
         end
         smart_status_pkg::ST_SEND:
         begin
            s_d.rd_data = out_byte;
            s_d.rd_valid = 1'b1;
            s_d.sum = s_q.sum + out_byte;
            // wraps after the checksum byte, when the phase moves on anyway
            s_d.ofs = s_q.ofs + 9'h001;
            if (in_entries)
            begin
               if (s_q.sub_ofs == `ENTRY_LAST_IDX)
               begin
                  s_d.sub_ofs = 4'h0;
                  s_d.idx = s_q.idx + 5'h01;
               end
               else
                  s_d.sub_ofs = s_q.sub_ofs + 4'h1;
            end
            if (s_q.ofs == `STRUCT_LAST)
               s_d.phase = smart_status_pkg::ST_DONE;
         end
         smart_status_pkg::ST_DONE:
         begin
            s_d.busy = 1'b0;
            // assigned after the acknowledge clear, so the set wins
            s_d.intrq = 1'b1;
            s_d.phase = smart_status_pkg::ST_IDLE;
         end
         default: s_d.phase = smart_status_pkg::ST_IDLE;
      endcase
   end

   // -------------------------------------------------------------------
   // state register
   // -------------------------------------------------------------------
   // the feature state clears too; it is not kept across a reset
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   // -------------------------------------------------------------------
   // registered outputs
   // -------------------------------------------------------------------
   // power-event saving is left to the store owner; disable gates nothing
   // here
   assign busy = s_q.busy;
   assign intrq = s_q.intrq;
   assign cyl_low = s_q.cyl_lo;
   assign cyl_high = s_q.cyl_hi;
   assign data_byte = s_q.rd_data;
   assign data_valid = s_q.rd_valid;
   assign cmd_error = s_q.err;
   assign auto_offline_en = s_q.auto_en;
   assign save_req = s_q.save_req;

endmodule : smart_status_attribute_report

// >>> sim/ata_host_model.sv
`timescale 1ns/1ps
module ata_host_model
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic go,
   input wire logic [7:0] go_sub,
   input wire logic [7:0] go_count,
   input wire logic intrq,
   output logic cmd_valid,
   output logic [7:0] cmd_sub,
   output logic [7:0] cmd_sector_count,
   output logic intrq_ack
);
   // count goes out with the command and is held until the next one
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         cmd_valid <= 1'b0;
         cmd_sub <= 8'h00;
         cmd_sector_count <= 8'h00;
         intrq_ack <= 1'b0;
      end
      else
      begin
         cmd_valid <= go;
         intrq_ack <= intrq && !intrq_ack;
         if (go)
         begin
            cmd_sub <= go_sub;
            cmd_sector_count <= go_count;
         end
      end
   end
endmodule : ata_host_model

// >>> sim/smart_status_attribute_report_chk.sv
`timescale 1ns/1ps
module smart_status_attribute_report_chk
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_sub,
   input wire logic [7:0] cmd_sector_count,
   input wire logic busy,
   input wire logic intrq,
   input wire logic [7:0] cyl_low,
   input wire logic [7:0] cyl_high,
   input wire logic data_valid,
   input wire logic cmd_error,
   input wire logic auto_offline_en,
   input wire logic save_req
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   logic take;
   logic db;
   logic [9:0] cnt_q;
   logic [9:0] cnt_d;
   assign take = cmd_valid && !busy;
   assign db = take && cmd_sub == 8'hdb;
   // ----------------------------------------
   // byte counter of the current read
   // ----------------------------------------
   always_comb
   begin
      cnt_d = cnt_q;
      if (take)
         cnt_d = 10'h000;
      else if (data_valid)
         cnt_d = cnt_q + 10'h001;
   end
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         cnt_q <= 10'h000;
      else
         cnt_q <= cnt_d;
   end
   property p_short; take && (cmd_sub == 8'hda || cmd_sub == 8'hdb)
      |=> busy ##1 busy ##1 (!busy && intrq); endproperty
   a_short: assert property (p_short) else $error("short cmd timing");
   property p_save; take && cmd_sub == 8'hda |=> !save_req ##1 save_req;
   endproperty
   a_save: assert property (p_save) else $error("no save pulse");
   property p_cyl; save_req |-> (cyl_low == 8'h4f && cyl_high == 8'hc2)
      || (cyl_low == 8'hf4 && cyl_high == 8'h2c); endproperty
   a_cyl: assert property (p_cyl) else $error("bad cyl answer");
   property p_rd; take && cmd_sub == 8'hd0
      |=> !data_valid ##1 !data_valid ##1 data_valid [*8]; endproperty
   a_rd: assert property (p_rd) else $error("read start");
   property p_cnt; $fell(data_valid) |-> cnt_q == 10'h200; endproperty
   a_cnt: assert property (p_cnt) else $error("byte count");
   property p_dvb; data_valid |-> busy && !intrq; endproperty
   a_dvb: assert property (p_dvb) else $error("data outside busy");
   property p_on; db && cmd_sector_count == 8'hf8
      |=> ##1 auto_offline_en && !cmd_error; endproperty
   a_on: assert property (p_on) else $error("enable key");
   property p_off; db && cmd_sector_count == 8'h00
      |=> ##1 !auto_offline_en; endproperty
   a_off: assert property (p_off) else $error("disable key");
   property p_keep; db && cmd_sector_count != 8'h00
      && cmd_sector_count != 8'hf8
      |=> ##1 cmd_error && $stable(auto_offline_en); endproperty
   a_keep: assert property (p_keep) else $error("other key");
endmodule : smart_status_attribute_report_chk
bind smart_status_attribute_report smart_status_attribute_report_chk u_chk
   (.*);

// >>> sim/smart_status_attribute_report_bench.sv
`timescale 1ns/1ps
module smart_status_attribute_report_bench;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic go = 1'b0;
   logic [7:0] go_sub = 8'h00;
   logic [7:0] go_count = 8'h00;
   logic cmd_valid, intrq_ack, busy, intrq, data_valid, cmd_error;
   logic auto_offline_en, save_req;
   logic [7:0] cmd_sub, cmd_sector_count, cyl_low, cyl_high, data_byte;
   logic [29:0][7:0] attr_id, attr_flags, attr_value, attr_threshold;
   logic [29:0] attr_updated = 30'h0;
   logic [6:0] offline_state = 7'h00;
   logic [7:0] selftest_status = 8'h5a;
   logic [15:0] offline_seconds = 16'h1234;
   logic [7:0] segment_ptr = 8'h07;
   logic [7:0] mem [512];
   int nbytes, err_total, num_checks;
   always #2.5 core_clk = ~core_clk;
   smart_status_attribute_report u_dut (.*);
   ata_host_model u_host (.*);
   always @(negedge core_clk)
      if (data_valid === 1'b1)
      begin
         mem[nbytes[8:0]] = data_byte;
         nbytes++;
      end
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic run(input logic [7:0] s, input logic [7:0] c);
      int n;
      n = 0;
      nbytes = 0;
      @(posedge core_clk);
      go <= 1'b1;
      go_sub <= s;
      go_count <= c;
      @(posedge core_clk);
      go <= 1'b0;
      @(negedge core_clk);
      while (!(intrq === 1'b1 && busy === 1'b0) && n < 600)
      begin
         @(negedge core_clk);
         n++;
      end
      chk({7'h00, intrq}, 8'h01);
   endtask : run
   task automatic t_status;
      run(8'hda, 8'h00);
      chk(cyl_low, 8'h4f);
      chk(cyl_high, 8'hc2);
      @(posedge core_clk);
      attr_updated[0] <= 1'b1;
      run(8'hda, 8'h00);
      chk(cyl_low, 8'hf4);
      chk(cyl_high, 8'h2c);
   endtask : t_status
   task automatic t_auto;
      logic [7:0] key [4] = '{8'hf8, 8'h55, 8'h00, 8'h01};
      logic [7:0] exp [4] = '{8'h01, 8'h03, 8'h00, 8'h02};
      for (int i = 0; i < 4; i++)
      begin
         run(8'hdb, key[i]);
         chk({6'h00, cmd_error, auto_offline_en}, exp[i]);
      end
      run(8'h77, 8'h00);
      chk({6'h00, cmd_error, auto_offline_en}, 8'h02);
   endtask : t_auto
   task automatic t_read;
      logic [6:0] code [5] = '{7'h00, 7'h02, 7'h04, 7'h05, 7'h06};
      logic [7:0] sum;
      for (int i = 0; i < 5; i++)
      begin
         run(8'hdb, i[0] ? 8'hf8 : 8'h00);
         @(posedge core_clk);
         offline_state <= code[i];
         run(8'hd0, 8'h00);
         sum = 8'h00;
         foreach (mem[j])
            sum += mem[j];
         chk(nbytes[9:2], 8'h80);
         chk({6'h00, nbytes[1:0]}, 8'h00);
         chk(sum, 8'h00);
         chk(mem[0], 8'h10);
         chk(mem[1], 8'h00);
         chk(mem[2], 8'h01);
         chk(mem[3], 8'h03);
         chk(mem[5], 8'h10);
         chk(mem[14], 8'h00);
         chk(mem[26], 8'hc2);
         chk(mem[29], 8'h01);
         chk(mem[9'h15e], 8'hc7);
         chk(mem[9'h15f], 8'h02);
         chk(mem[9'h161], 8'hfd);
         chk(mem[9'h16a], {i[0], code[i]});
         chk(mem[9'h16b], 8'h5a);
         chk(mem[9'h16c], 8'h34);
         chk(mem[9'h16d], 8'h12);
         chk(mem[9'h16e], 8'h07);
         chk(mem[9'h16f], 8'h1b);
         chk(mem[9'h170], 8'h03);
         chk(mem[9'h171], 8'h00);
         chk(mem[9'h172], 8'h01);
      end
   endtask : t_read
   task automatic summarize;
      if (err_total == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : summarize
   initial
   begin
      // entry 0 below threshold but not updated at first
      attr_id = '0;
      attr_flags = '0;
      attr_value = '0;
      attr_threshold = '0;
      attr_id[0] = 8'h01;
      attr_flags[0] = 8'h03;
      attr_value[0] = 8'h10;
      attr_threshold[0] = 8'h20;
      attr_id[1] = 8'h06;
      attr_id[2] = 8'hc2;
      attr_flags[29] = 8'hc2;
      attr_value[29] = 8'hff;
      attr_id[29] = 8'hc7;
      repeat (10) @(posedge core_clk);
      rst <= 1'b0;
      t_status();
      t_auto();
      t_read();
      summarize();
   end
   // about 3000 cycles are needed; generous margin for slow reads
   initial
   begin
      #(20000 * 5);
      err_total++;
      summarize();
   end
endmodule : smart_status_attribute_report_bench
